// ### src/dao_pkg.sv
package dao_pkg;
    // clock and documented analog times, kept in their own units
    localparam int unsigned CLK_PERIOD_PS = 20000;
    localparam int unsigned AONPD_MAX_PS = 8500;
    localparam int unsigned AOFPD_MIN_PS = 2000;
    localparam int unsigned AOFPD_MAX_PS = 8500;
    localparam int unsigned RFC_NS = 160;

    // least times round up, longest round down, the async delay never below one cycle
    localparam int unsigned ASYNC_MIN_CYC = (AOFPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned ASYNC_MAX_RAW = AONPD_MAX_PS / CLK_PERIOD_PS;
    localparam int unsigned ASYNC_DLY_CYC = (ASYNC_MIN_CYC < 1) ? 1 : ASYNC_MIN_CYC;
    localparam int unsigned RFC_CYC = (RFC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // register map
    localparam logic [3:0] ADDR_CFG = 4'h0;
    localparam logic [3:0] ADDR_TIM = 4'h1;
    localparam logic [3:0] ADDR_RFC = 4'h2;
    localparam logic [3:0] ADDR_STAT = 4'h3;

    // config fields
    localparam int unsigned CFG_FRZ_BIT = 0;
    localparam int unsigned CFG_CWL_LSB = 4;
    localparam int unsigned CFG_AL_LSB = 8;
    localparam int unsigned TIM_CPDED_LSB = 0;
    localparam int unsigned TIM_XPDLL_LSB = 8;

    // status fields
    localparam int unsigned STAT_RTT = 0;
    localparam int unsigned STAT_ASYNC = 1;
    localparam int unsigned STAT_WIN = 2;
    localparam int unsigned STAT_PD = 3;
    localparam int unsigned STAT_IGN = 4;

    // reset values
    localparam logic FRZ_RST = 1'b0;
    localparam logic [3:0] CWL_RST = 4'h5;
    localparam logic [3:0] AL_RST = 4'h0;
    localparam logic [7:0] CPDED_RST = 8'h01;
    localparam logic [7:0] XPDLL_RST = 8'h0a;
    localparam logic [7:0] RFC_RST = 8'(RFC_CYC);

    // latency offsets in clocks
    localparam logic [4:0] ODTL_OFS = 5'h02;
    localparam logic [4:0] ANPD_OFS = 5'h01;

    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_ENTRY = 2'b01,
        ST_PDOWN = 2'b11,
        ST_EXIT = 2'b10
    } dao_state_type;
endpackage

// ### src/dao_odt_pipe.sv
`timescale 1ns/100ps
module dao_odt_pipe #(
    parameter int unsigned DEPTH = 32,
    parameter int unsigned AW = 5
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic odt_in,
    input wire logic [AW-1:0] sync_tap_in,
    input wire logic [AW-1:0] async_tap_in,
    output logic sync_out,
    output logic async_out
);
    logic [DEPTH-1:0] pipe_q;

    // tap 0 is the pin itself, tap n is n cycles old
    function automatic logic tap(input logic [DEPTH-1:0] p, input logic o,
                                 input logic [AW-1:0] n);
        logic r;
        r = o;
        if (n != '0) begin
            r = p[n - 1'b1];
        end
        return r;
    endfunction

    // history runs in every mode so a return to clocked timing is seamless
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pipe_q <= '0;
        end else begin
            pipe_q <= {pipe_q[DEPTH-2:0], odt_in};
        end
    end

    assign sync_out = tap(pipe_q, odt_in, sync_tap_in);
    assign async_out = tap(pipe_q, odt_in, async_tap_in);
endmodule

// ### src/dao_win_timer.sv
`timescale 1ns/100ps
module dao_win_timer #(
    parameter int unsigned W = 8
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic load_in,
    input wire logic [W-1:0] count_in,
    output logic active_out,
    output logic [W-1:0] remain_out
);
    logic [W-1:0] cnt_q;

    // load restarts the window even when it is already running
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q <= '0;
        end else if (load_in) begin
            cnt_q <= count_in;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign active_out = (cnt_q != '0);
    assign remain_out = cnt_q;
endmodule

// ### src/dao_odt_ctrl.sv
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
// What this block does
// - frozen-DLL setting in power-down selects asynchronous termination control
// - asynchronous mode applies the pin without additive latency
// - async turn-on lands between its minimum and 8.5 ns after sampling; here it lands one 20 ns clock after sampling
// - async turn-off lands between 2 ns and 8.5 ns after sampling; here it lands one 20 ns clock after sampling
// - pin receiver stays live in power-down; reads and writes are refused
// - turn-on inside a window lies between async and clocked bounds
// - turn-off inside a window lies between async and clocked bounds
// - entry window opens write latency minus one before CKE low, start excluded; here it opens at the first low registration of CKE
// - entry window ends inclusively after the entry delay, frozen setting only
// - refresh in progress stretches entry window to the refresh cycle end
// - exit window runs from before CKE high to DLL exit delay after; here it opens at the first high registration of CKE
// - after the exit window the pin is followed with clocked latency
// - overlapping entry then exit windows merge into one uncertain span
// - overlapping exit then entry windows merge into one uncertain span
module dao_odt_ctrl #(
    parameter int unsigned PIPE_DEPTH = 32,
    parameter int unsigned TW = 8
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic cke_in,
    input wire logic odt_in,
    input wire logic refresh_cmd_in,
    input wire logic rd_cmd_in,
    input wire logic wr_cmd_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    output logic cmd_accept_out,
    output logic rtt_on_out,
    output logic async_mode_out,
    output logic transition_out,
    output logic power_down_out
);
    logic frz_q;
    logic [3:0] cwl_q;
    logic [3:0] al_q;
    logic [TW-1:0] cpded_q;
    logic [TW-1:0] xpdll_q;
    logic [TW-1:0] rfc_q;
    logic cke_q;
    logic ign_q;
    logic rtt_q;
    logic win_q;
    logic [15:0] rdata_q;
    dao_pkg::dao_state_type state_q;
    dao_pkg::dao_state_type state_d;
    logic cke_fall;
    logic cke_rise;
    logic frozen;
    logic entry_act;
    logic exit_act;
    logic rfc_act;
    logic [TW-1:0] rfc_left;
    logic [TW-1:0] entry_len;
    logic [4:0] sync_lat;
    logic [4:0] sync_tap;
    logic [4:0] async_tap;
    logic odt_sync;
    logic odt_async;
    logic async_sel;
    logic rdwr_pd;

    // larger of two window lengths, used for refresh stretch
    function automatic logic [TW-1:0] max_len(input logic [TW-1:0] a, input logic [TW-1:0] b);
        return (a > b) ? a : b;
    endfunction

    // A12 written as zero freezes the DLL in precharge power-down
    assign frozen = (frz_q == 1'b0);
    assign cke_fall = cke_q && !cke_in;
    assign cke_rise = !cke_q && cke_in;

    // clocked latency: write latency (al + cwl) minus two
    assign sync_lat = 5'(al_q) + 5'(cwl_q) - dao_pkg::ODTL_OFS;
    assign sync_tap = sync_lat - 5'h01;
    // async path skips al entirely
    assign async_tap = 5'(dao_pkg::ASYNC_DLY_CYC - 1);

    dao_odt_pipe #(
        .DEPTH(PIPE_DEPTH),
        .AW(5)
    ) u_pipe (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .odt_in(odt_in),
        .sync_tap_in(sync_tap),
        .async_tap_in(async_tap),
        .sync_out(odt_sync),
        .async_out(odt_async)
    );

    // entry window length, refresh may stretch it past the entry delay
    assign entry_len = max_len(cpded_q, rfc_act ? rfc_left : '0);

    dao_win_timer #(.W(TW)) u_rfc (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .load_in(refresh_cmd_in),
        .count_in(rfc_q),
        .active_out(rfc_act),
        .remain_out(rfc_left)
    );

    dao_win_timer #(.W(TW)) u_entry (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .load_in(cke_fall && frozen),
        .count_in(entry_len),
        .active_out(entry_act),
        .remain_out()
    );

    dao_win_timer #(.W(TW)) u_exit (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .load_in(cke_rise && (state_q != dao_pkg::ST_ACTIVE)),
        .count_in(xpdll_q),
        .active_out(exit_act),
        .remain_out()
    );

    // registered view of the clock enable pin
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cke_q <= 1'b1;
        end else begin
            cke_q <= cke_in;
        end
    end

    // mode sequence; windows that overlap keep the span open until both end
    always_comb begin
        state_d = state_q;
        case (state_q)
            dao_pkg::ST_ACTIVE: begin
                if (cke_fall && frozen) begin
                    state_d = dao_pkg::ST_ENTRY;
                end
            end
            dao_pkg::ST_ENTRY: begin
                if (cke_rise) begin
                    state_d = dao_pkg::ST_EXIT;
                end else if (!entry_act && !exit_act) begin
                    state_d = dao_pkg::ST_PDOWN;
                end
            end
            dao_pkg::ST_PDOWN: begin
                if (cke_rise) begin
                    state_d = dao_pkg::ST_EXIT;
                end
            end
            dao_pkg::ST_EXIT: begin
                if (cke_fall) begin
                    state_d = dao_pkg::ST_ENTRY;
                end else if (!exit_act && !entry_act) begin
                    state_d = dao_pkg::ST_ACTIVE;
                end
            end
            default: begin
                state_d = dao_pkg::ST_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= dao_pkg::ST_ACTIVE;
        end else begin
            state_q <= state_d;
        end
    end

    // async from the first low registration of cke until the exit window ends;
    // changes already queued in the clocked pipe then land early, which is
    // what makes the span before cke low uncertain
    assign async_sel = (state_q != dao_pkg::ST_ACTIVE);

    // termination output; inside windows either timing is legal
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rtt_q <= 1'b0;
        end else if (async_sel) begin
            rtt_q <= odt_async;
        end else begin
            rtt_q <= odt_sync;
        end
    end

    // window flag: union of entry, exit and refresh stretch
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            win_q <= 1'b0;
        end else begin
            win_q <= (state_d == dao_pkg::ST_ENTRY) || (state_d == dao_pkg::ST_EXIT);
        end
    end

    // commands are refused while cke is registered low
    assign rdwr_pd = (rd_cmd_in || wr_cmd_in) && !cke_q;
    assign cmd_accept_out = (rd_cmd_in || wr_cmd_in) && cke_q;

    // sticky refused-command flag, write one clears, a new event wins
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ign_q <= 1'b0;
        end else if (rdwr_pd) begin
            ign_q <= 1'b1;
        end else if (reg_wr_in && reg_addr_in == dao_pkg::ADDR_STAT
                     && reg_wdata_in[dao_pkg::STAT_IGN]) begin
            ign_q <= 1'b0;
        end
    end

    // software configuration
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            frz_q <= dao_pkg::FRZ_RST;
            cwl_q <= dao_pkg::CWL_RST;
            al_q <= dao_pkg::AL_RST;
            cpded_q <= dao_pkg::CPDED_RST;
            xpdll_q <= dao_pkg::XPDLL_RST;
            rfc_q <= dao_pkg::RFC_RST;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                dao_pkg::ADDR_CFG: begin
                    frz_q <= reg_wdata_in[dao_pkg::CFG_FRZ_BIT];
                    cwl_q <= reg_wdata_in[dao_pkg::CFG_CWL_LSB +: 4];
                    al_q <= reg_wdata_in[dao_pkg::CFG_AL_LSB +: 4];
                end
                dao_pkg::ADDR_TIM: begin
                    cpded_q <= reg_wdata_in[dao_pkg::TIM_CPDED_LSB +: TW];
                    xpdll_q <= reg_wdata_in[dao_pkg::TIM_XPDLL_LSB +: TW];
                end
                dao_pkg::ADDR_RFC: begin
                    rfc_q <= reg_wdata_in[TW-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_q <= '0;
        end else if (reg_rd_in) begin
            rdata_q <= '0;
            case (reg_addr_in)
                dao_pkg::ADDR_CFG: begin
                    rdata_q[dao_pkg::CFG_FRZ_BIT] <= frz_q;
                    rdata_q[dao_pkg::CFG_CWL_LSB +: 4] <= cwl_q;
                    rdata_q[dao_pkg::CFG_AL_LSB +: 4] <= al_q;
                end
                dao_pkg::ADDR_TIM: begin
                    rdata_q[dao_pkg::TIM_CPDED_LSB +: TW] <= cpded_q;
                    rdata_q[dao_pkg::TIM_XPDLL_LSB +: TW] <= xpdll_q;
                end
                dao_pkg::ADDR_RFC: begin
                    rdata_q[TW-1:0] <= rfc_q;
                end
                dao_pkg::ADDR_STAT: begin
                    rdata_q[dao_pkg::STAT_RTT] <= rtt_q;
                    rdata_q[dao_pkg::STAT_ASYNC] <= async_sel;
                    rdata_q[dao_pkg::STAT_WIN] <= win_q;
                    rdata_q[dao_pkg::STAT_PD] <= !cke_q;
                    rdata_q[dao_pkg::STAT_IGN] <= ign_q;
                end
                default: begin
                end
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign rtt_on_out = rtt_q;
    assign async_mode_out = async_sel;
    assign transition_out = win_q;
    assign power_down_out = !cke_q;

    AST_ASYNC_NEEDS_FREEZE: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        $rose(async_sel) |-> $past(frozen))
        else $error("async mode entered without frozen dll setting");

    AST_ASYNC_ON: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (state_q == dao_pkg::ST_PDOWN && odt_in && state_d == dao_pkg::ST_PDOWN) |=> rtt_on_out)
        else $error("async turn-on missed its one-cycle bound");

    AST_ASYNC_OFF: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (state_q == dao_pkg::ST_PDOWN && !odt_in && state_d == dao_pkg::ST_PDOWN) |=> !rtt_on_out)
        else $error("async turn-off missed its one-cycle bound");

    AST_NO_AL_ASYNC: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (state_q == dao_pkg::ST_PDOWN)[*2] |-> rtt_on_out == $past(odt_in))
        else $error("async path delayed beyond one cycle");

    AST_CMD_REFUSED: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        rdwr_pd |-> !cmd_accept_out ##1 ign_q)
        else $error("command in power-down not refused");

    AST_ENTRY_OPEN: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (cke_fall && frozen && state_q == dao_pkg::ST_ACTIVE) |=> transition_out && async_sel)
        else $error("entry window did not open at cke low");

    AST_ENTRY_HOLD: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (state_q == dao_pkg::ST_ENTRY && entry_act && !cke_rise) |=> transition_out)
        else $error("entry window closed early");

    AST_RFC_STRETCH: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (cke_fall && frozen && rfc_act && rfc_left > cpded_q) |=> entry_act[*2])
        else $error("refresh did not stretch entry window");

    AST_EXIT_OPEN: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (state_q == dao_pkg::ST_PDOWN && cke_rise) |=> state_q == dao_pkg::ST_EXIT && transition_out)
        else $error("exit window did not open at cke high");

    AST_SYNC_AFTER: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (state_q == dao_pkg::ST_ACTIVE && state_d == dao_pkg::ST_ACTIVE) |=> rtt_on_out == $past(odt_sync))
        else $error("clocked latency not used after exit");

    AST_OVERLAP_ENTRY_EXIT: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (state_q == dao_pkg::ST_EXIT && entry_act) |=> transition_out)
        else $error("merged entry-exit span broke early");

    AST_OVERLAP_EXIT_ENTRY: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (state_q == dao_pkg::ST_ENTRY && exit_act) |=> transition_out)
        else $error("merged exit-entry span broke early");

    AST_NO_WIN_UNFROZEN: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (state_q == dao_pkg::ST_ACTIVE && !frozen) |=> !async_sel && !transition_out)
        else $error("window opened without frozen dll setting");

    AST_EXIT_ASYNC_PATH: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
        (state_q == dao_pkg::ST_EXIT) |=> rtt_on_out == $past(odt_in))
        else $error("exit window did not follow the pin on the fast path");
endmodule

// ### dv/dao_ctrl_model.sv
`timescale 1ns/100ps
module dao_ctrl_model #(
    parameter int unsigned WIN = 16
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic pd_req_in,
    input wire logic odt_req_in,
    input wire logic ref_req_in,
    input wire logic rd_req_in,
    input wire logic wr_req_in,
    input wire logic misuse_in,
    output logic cke_out,
    output logic odt_out,
    output logic refresh_out,
    output logic rd_out,
    output logic wr_out,
    output logic uncertain_out
);
    logic [7:0] win_q;

    // pins move just after the edge, as a real controller drives them
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cke_out <= 1'b1;
            odt_out <= 1'b0;
            refresh_out <= 1'b0;
            rd_out <= 1'b0;
            wr_out <= 1'b0;
        end else begin
            cke_out <= !pd_req_in;
            odt_out <= odt_req_in;
            refresh_out <= ref_req_in;
            // no commands while asleep unless a misuse is ordered
            rd_out <= rd_req_in && (cke_out || misuse_in);
            wr_out <= wr_req_in && (cke_out || misuse_in);
        end
    end

    // termination is uncertain for a while around every cke change
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            win_q <= 8'h00;
        end else if (cke_out != !pd_req_in) begin
            win_q <= 8'(WIN);
        end else if (win_q != 8'h00) begin
            win_q <= win_q - 8'h01;
        end
    end
    assign uncertain_out = (win_q != 8'h00);
endmodule

// ### dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic core_clk, rstn, reg_wr, reg_rd, pd_req, odt_req, ref_req, rd_req, wr_req, misuse;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic cke, odt, refresh, rd_cmd, wr_cmd, accept, rtt, async_mode, win, pd, unc;
    int n_fail = 0;
    int checks_done = 0;

    dao_ctrl_model ctl (.core_clk_in(core_clk), .rstn_in(rstn), .pd_req_in(pd_req),
        .odt_req_in(odt_req), .ref_req_in(ref_req), .rd_req_in(rd_req), .wr_req_in(wr_req),
        .misuse_in(misuse), .cke_out(cke), .odt_out(odt), .refresh_out(refresh),
        .rd_out(rd_cmd), .wr_out(wr_cmd), .uncertain_out(unc));
    dao_odt_ctrl dut (.core_clk_in(core_clk), .rstn_in(rstn), .cke_in(cke), .odt_in(odt),
        .refresh_cmd_in(refresh), .rd_cmd_in(rd_cmd), .wr_cmd_in(wr_cmd),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .cmd_accept_out(accept),
        .rtt_on_out(rtt), .async_mode_out(async_mode), .transition_out(win),
        .power_down_out(pd));

    // free-running core clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // a count outside its span is shown against the lower bound
    task automatic chk_rng(input int got, input int lo, input int hi);
        chk(16'((got >= lo && got <= hi) ? lo : got), 16'(lo));
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        tick(1);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick(1);
        reg_rd <= 1'b0;
        chk(reg_rdata, exp);
        // one idle edge so a following read never re-assigns the strobe at once
        tick(1);
        chk(reg_rdata, 16'h0000);
    endtask

    task automatic flags(input logic [2:0] e);
        chk({13'h0, async_mode, win, pd}, {13'h0, e});
    endtask

    // edges from the sampling edge of the pin until termination follows
    task automatic lat(input logic tgt, input int lo, input int hi);
        int n;
        n = 0;
        odt_req <= tgt;
        tick(1);
        while (rtt !== tgt && n < 40) begin
            tick(1);
            n++;
        end
        chk_rng(n, lo, hi);
    endtask

    // length of the next window; a gap in a merged window shortens it
    task automatic span(input int lo, input int hi);
        int n;
        int w;
        n = 0;
        w = 0;
        while (win !== 1'b1 && w < 20) begin
            tick(1);
            w++;
        end
        // controller must already treat termination as uncertain here
        chk({15'h0, unc}, 16'h0001);
        while (win === 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        chk_rng(n, lo, hi);
    endtask

    task automatic cmd(input logic bad, input logic w, input logic exp);
        misuse <= bad;
        rd_req <= !w;
        wr_req <= w;
        tick(1);
        rd_req <= 1'b0;
        wr_req <= 1'b0;
        misuse <= 1'b0;
        chk({15'h0, accept}, {15'h0, exp});
        tick(2);
    endtask

    task automatic t_regs();
        rd_chk(dao_pkg::ADDR_CFG, 16'h0050);
        rd_chk(dao_pkg::ADDR_TIM, 16'h0a01);
        rd_chk(dao_pkg::ADDR_RFC, 16'h0008);
        rd_chk(dao_pkg::ADDR_STAT, 16'h0000);
        wr_reg(4'h7, 16'hffff);
        rd_chk(4'h7, 16'h0000);
    endtask

    task automatic t_sync();
        lat(1'b1, 3, 4);
        lat(1'b0, 3, 4);
        cmd(1'b0, 1'b0, 1'b1);
        cmd(1'b0, 1'b1, 1'b1);
        wr_reg(dao_pkg::ADDR_CFG, 16'h0250);
        lat(1'b1, 5, 6);
        lat(1'b0, 5, 6);
    endtask

    task automatic t_pd();
        wr_reg(dao_pkg::ADDR_TIM, 16'h0604);
        pd_req <= 1'b1;
        span(4, 5);
        flags(3'b101);
        lat(1'b1, 1, 1);
        lat(1'b0, 1, 1);
        rd_chk(dao_pkg::ADDR_STAT, 16'h000a);
        cmd(1'b1, 1'b0, 1'b0);
        rd_chk(dao_pkg::ADDR_STAT, 16'h001a);
        wr_reg(dao_pkg::ADDR_STAT, 16'h0010);
        rd_chk(dao_pkg::ADDR_STAT, 16'h000a);
        pd_req <= 1'b0;
        span(6, 7);
        flags(3'b000);
        lat(1'b1, 5, 6);
        lat(1'b0, 5, 6);
    endtask

    task automatic t_windows();
        wr_reg(dao_pkg::ADDR_TIM, 16'h1e04);
        pd_req <= 1'b1;
        span(4, 5);
        pd_req <= 1'b0;
        tick(3);
        lat(1'b1, 1, 6);
        lat(1'b0, 1, 6);
        tick(40);
        wr_reg(dao_pkg::ADDR_TIM, 16'h0601);
        ref_req <= 1'b1;
        tick(1);
        ref_req <= 1'b0;
        pd_req <= 1'b1;
        span(5, 9);
        pd_req <= 1'b0;
        tick(20);
    endtask

    task automatic t_short();
        wr_reg(dao_pkg::ADDR_TIM, 16'h0604);
        pd_req <= 1'b1;
        tick(1);
        pd_req <= 1'b0;
        span(6, 12);
        tick(5);
        flags(3'b000);
        pd_req <= 1'b1;
        span(4, 5);
        tick(3);
        pd_req <= 1'b0;
        tick(1);
        pd_req <= 1'b1;
        span(6, 12);
        flags(3'b101);
        pd_req <= 1'b0;
        tick(20);
    endtask

    task automatic t_frz();
        wr_reg(dao_pkg::ADDR_CFG, 16'h0251);
        pd_req <= 1'b1;
        tick(10);
        flags(3'b001);
        lat(1'b1, 5, 6);
        lat(1'b0, 5, 6);
        pd_req <= 1'b0;
        tick(3);
    endtask

    // cut a hang short
    initial begin
        #200000;
        n_fail++;
        conclude();
    end

    // main sequence
    initial begin
        rstn = 1'b0;
        {reg_wr, reg_rd, pd_req, odt_req, ref_req, rd_req, wr_req, misuse} = 8'h00;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        tick(1);
        t_regs();
        t_sync();
        t_pd();
        t_windows();
        t_short();
        t_frz();
        conclude();
    end
endmodule
